// [bench/madc_conv_model.sv]
// madc_conv_model: behavioural converter macro, answers each start after lat+1 cycles.
// assumes one converter; off conversion the data lines show the inverse of the sample.
`timescale 1ns/10ps
module madc_conv_model
  import madc_pkg::*;
(
  input wire logic            sys_clk, conv_pd, conv_start, conv_tsd,
  input wire logic [7:0]      lat,        // conversion time, prompt or slow
  input wire logic [CH_W-1:0] conv_chsel,
  output logic                conv_eoc,
  output logic [DAT_W-1:0]    conv_dout
);
  logic [7:0]       cnt; // cycles into the conversion
  logic [DAT_W-1:0] smp; // sample derived from the selection, so the bench can predict it
  assign smp = {conv_tsd, 6'h2a, conv_chsel};
  always @(posedge sys_clk) begin
    if (conv_start !== 1'b1 || conv_pd !== 1'b0) begin cnt <= 8'h00; conv_eoc <= 1'b0; conv_dout <= ~smp; end
    else if (cnt == lat) begin conv_eoc <= 1'b1; conv_dout <= smp; end // held until start drops
    else cnt <= cnt + 8'h01;
  end
endmodule : madc_conv_model

// [bench/madc_top_asserts.sv]
// madc_top_asserts: port checks of the converter controller, bound into madc_top.
// assumes one sys_clk domain; lane 0 of the converter ports is watched.
`timescale 1ns/10ps
module madc_top_asserts
  import madc_pkg::*;
#(parameter int NCONV = 1)(
  // apb and converter ports seen from outside
  input wire logic                  sys_clk, rst_n, psel, penable, pready, pslverr, conv_pd, conv_start,
  input wire logic [NCONV-1:0]      conv_tsd, conv_eoc, thr_valid,
  input wire logic [NCONV*CH_W-1:0] conv_chsel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] idle_cnt; // cycles since start dropped; saturates so the first start passes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) idle_cnt <= 8'hff;
    else if (conv_start) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
  end
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  wait_state_a: assert property (psel && $rose(penable) |=> pready) else $error("no answer");
  error_with_a: assert property (pslverr |-> pready) else $error("stray slave error");
  start_clear_a: assert property ($rose(conv_start) |-> conv_eoc == '0) else $error("start early");
  grant_bound_a: assert property (conv_start && conv_eoc[0] |-> ##[1:6] !conv_start) else $error("no grant");
  resp_gap_a: assert property ($rose(conv_start) |-> idle_cnt >= 8'h12) else $error("gap short");
  chan_hold_a: assert property (conv_start && $past(conv_start) |-> $stable(conv_chsel)) else $error("chan moved");
  powered_start_a: assert property (conv_start |-> !conv_pd) else $error("start while off");
  temp_map_a: assert property (conv_start |-> conv_tsd[0] == (conv_chsel[CH_W-1:0] == '0)) else $error("map");
  thr_pulse_a: assert property (thr_valid[0] |=> !thr_valid[0]) else $error("violation held");
endmodule : madc_top_asserts
bind madc_top madc_top_asserts #(.NCONV(NCONV)) madc_top_asserts_i (.sys_clk, .rst_n, .psel, .penable, .pready,
  .pslverr, .conv_pd, .conv_start, .conv_tsd, .conv_eoc, .thr_valid, .conv_chsel);

// [bench/madc_top_test.sv]
// madc_top_test: register-level tests of the converter controller with a behavioural macro.
// assumes a one-converter build of two slots: channel 3, then the temperature sensor.
`timescale 1ns/10ps
module madc_top_test
  import madc_pkg::*;
;
  logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, conv_dout;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [7:0]  lat = 8'h03; // prompt converter first
  logic pready, pslverr, conv_pd, conv_start, conv_cont, block_irq, conv_tsd, conv_eoc, thr_valid, thr_above, thr_below;
  logic [4:0]  conv_chsel, thr_chan;
  int n_errors = 0, n_tests = 0, cyc = 0, n_viol = 0;
  always #25 sys_clk = ~sys_clk;
  madc_top #(.NUM_SLOTS(2), .SLOT_CHAN(320'h223), .MAX_LIMIT(12'h600), .MAX_EN(32'h00020008)) madc_top_i (.sys_clk,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .conv_pd, .conv_start, .conv_cont,
    .conv_tsd, .conv_chsel, .conv_eoc, .conv_dout, .thr_valid, .thr_above, .thr_below, .thr_chan, .block_irq);
  madc_conv_model madc_conv_model_i (.sys_clk, .lat, .conv_pd, .conv_start, .conv_tsd, .conv_chsel, .conv_eoc,
    .conv_dout);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end
  endtask : chk
  // one apb transfer; waits for pready, takes data at that edge, then idles one cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, exp, input logic err, cmp);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk({31'h0, pready}, 32'h1);
    rdata = prdata;
    if (cmp) chk({31'h0, pslverr}, {31'h0, err});
    if (cmp && !w) chk(rdata, exp);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer
  task automatic poll; // read the block flag until set, bounded
    int i;
    i = 0;
    do begin xfer(1'b0, OFS_ISR, 32'h0, 32'h0, 1'b0, 1'b0); i++; end while (rdata[0] !== 1'b1 && i < 2000);
    chk(rdata, 32'h1);
  endtask : poll
  task automatic results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // violation stream: only the sensor sample 12'hd40 exceeds the upper limit
  always @(posedge sys_clk) if (thr_valid === 1'b1) begin
    n_viol++;
    chk({25'h0, thr_below, thr_above, thr_chan}, 32'h31);
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin n_errors++; results(); end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    xfer(1'b0, OFS_CMD, 32'h0, 32'h0, 1'b0, 1'b1);
    xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b1, 1'b1);
    xfer(1'b1, OFS_CMD, 32'h1, 32'h0, 1'b0, 1'b1);
    poll();
    xfer(1'b0, OFS_CMD, 32'h0, 32'h0, 1'b0, 1'b1);
    xfer(1'b0, OFS_RAM, 32'h0, 32'h544, 1'b0, 1'b1);
    xfer(1'b0, OFS_RAM + 12'h004, 32'h0, 32'hd40, 1'b0, 1'b1);
    xfer(1'b1, OFS_RAM, 32'h5, 32'h0, 1'b1, 1'b1);
    chk(n_viol, 32'h1);
    xfer(1'b1, OFS_IER, 32'h1, 32'h0, 1'b0, 1'b1);
    xfer(1'b0, OFS_IER, 32'h0, 32'h1, 1'b0, 1'b1);
    chk({31'h0, block_irq}, 32'h1);
    xfer(1'b1, OFS_ISR, 32'h1, 32'h0, 1'b0, 1'b1);
    xfer(1'b0, OFS_ISR, 32'h0, 32'h0, 1'b0, 1'b1);
    chk({31'h0, block_irq}, 32'h0);
    $display("test single pass done");
    lat <= 8'h28; // slow converter for the continuous run
    xfer(1'b1, OFS_CMD, 32'h3, 32'h0, 1'b0, 1'b1);
    poll();
    xfer(1'b1, OFS_ISR, 32'h1, 32'h0, 1'b0, 1'b1);
    poll();
    xfer(1'b1, OFS_CMD, 32'h2, 32'h0, 1'b0, 1'b1);
    for (int i = 0; i < 2000 && conv_pd !== 1'b1; i++) @(posedge sys_clk);
    chk({31'h0, conv_pd}, 32'h1);
    xfer(1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0, 1'b1);
    chk({31'h0, conv_cont}, 32'h1);
    xfer(1'b0, OFS_RAM + 12'h004, 32'h0, 32'hd40, 1'b0, 1'b1);
    $display("test continuous done");
    results();
  end
endmodule : madc_top_test

// [logic/madc_pkg.sv]
// madc_pkg: shared constants and types of the modular converter controller.
// assumes a single 20 MHz system clock and an apb register bus with 12-bit byte addresses.
package madc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CH_W      = 5;               // logical channel number width
  localparam int DAT_W     = 12;              // converter sample width
  localparam int SLOT_W    = 6;               // slot index width
  localparam int MAX_SLOTS = 64;              // largest sequence the table can hold
  localparam int ADDR_W    = 12;              // apb byte address width
  localparam int CNT_W     = 8;               // wait counter width
  localparam int LANE_W    = 16;              // one converter's lane in a stored word

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CMD    = 12'h000; // run and mode
  localparam logic [ADDR_W-1:0] OFS_IER    = 12'h004; // block interrupt enable
  localparam logic [ADDR_W-1:0] OFS_ISR    = 12'h008; // block complete, write one to clear
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c; // sequencer and core state
  localparam logic [ADDR_W-1:0] OFS_RAM    = 12'h100; // sample words, one per slot
  localparam int                RAM_LSB    = 8;       // ram window decoded from this bit up

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int   CMD_RUN_BIT  = 0;
  localparam int   CMD_MODE_BIT = 1;              // 0 single pass, 1 continuous
  localparam int   IER_BLK_BIT  = 0;
  localparam int   ISR_BLK_BIT  = 0;
  localparam logic CMD_RUN_RST  = 1'b0;
  localparam logic CMD_MODE_RST = 1'b0;
  localparam logic IER_RST      = 1'b0;
  localparam logic ISR_RST      = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 50;                                  // sys_clk period
  localparam int RESP_GAP_NS  = 1000;                                // least response spacing
  localparam int RESP_GAP_CYC = (RESP_GAP_NS + CLK_NS - 1) / CLK_NS; // rounded up
  localparam int PWRUP_NS     = 2000;                                // converter settle after power up
  localparam int PWRUP_CYC    = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONT_WIN_CYC = 2;                                   // window for back-to-back commands

  // ----------------------------------------------------------------
  // channel map between logical and macro numbering
  // ----------------------------------------------------------------
  localparam logic [CH_W-1:0] TEMP_LCH = 5'h11; // logical temperature channel
  localparam logic [CH_W-1:0] TEMP_MCH = 5'h00; // macro code when the sensor is routed
  localparam logic [CH_W-1:0] PIN_OFS  = 5'h01; // macro counts analog pins from one

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_PWRUP, OP_PWRDN, OP_CONV} madc_op_type;
  typedef enum {ST_OFF, ST_PWRUP, ST_READY, ST_CONV, ST_GAP} madc_state_type;
  typedef enum {SEL_NONE, SEL_CMD, SEL_IER, SEL_ISR, SEL_STAT, SEL_RAM} madc_sel_type;

endpackage : madc_pkg

// [logic/madc_ram.sv]
// madc_ram: sample memory, one write port from the store, one registered read port.
// assumes both ports run on sys_clk; contents are not reset.
`timescale 1ns/10ps
module madc_ram
  import madc_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = MAX_SLOTS,
  parameter int AW    = SLOT_W
)(
  // clock
  input  wire logic             sys_clk,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];  // storage array

  // write side
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read side: registered so a read costs one cycle
  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : madc_ram

// [logic/madc_top.sv]
// madc_top: sequencer, converter control core, synchronizer, response merger,
// sample store and threshold checker behind one apb slave.
// assumes the converter macro raises eoc after start and holds data stable while eoc is high.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module madc_top
  import madc_pkg::*;
#(
  parameter int                           NCONV     = 1,         // converters, 1 or 2
  parameter int                           NUM_SLOTS = MAX_SLOTS, // sequence length
  parameter logic [NCONV*MAX_SLOTS*CH_W-1:0] SLOT_CHAN = '0,    // channel of each slot
  parameter logic [DAT_W-1:0]             MAX_LIMIT = 12'hfff,   // upper threshold
  parameter logic [DAT_W-1:0]             MIN_LIMIT = 12'h000,   // lower threshold
  parameter logic [31:0]                  MAX_EN    = 32'h0,     // per-channel upper check
  parameter logic [31:0]                  MIN_EN    = 32'h0,     // per-channel lower check
  parameter logic                         IRQ_EN    = 1'b1       // build the block interrupt
)(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic      [31:0]              prdata,
  output logic                          pslverr,
  // converter macro
  output logic                          conv_pd,
  output logic                          conv_start,
  output logic                          conv_cont,
  output logic      [NCONV-1:0]         conv_tsd,
  output logic      [NCONV*CH_W-1:0]    conv_chsel,
  input  wire logic [NCONV-1:0]         conv_eoc,
  input  wire logic [NCONV*DAT_W-1:0]   conv_dout,
  // threshold violation stream
  output logic      [NCONV-1:0]         thr_valid,
  output logic      [NCONV-1:0]         thr_above,
  output logic      [NCONV-1:0]         thr_below,
  output logic      [NCONV*CH_W-1:0]    thr_chan,
  // sample block interrupt
  output logic                          block_irq
);

  localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(NUM_SLOTS - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address decode, shared by the read and the write path
  function automatic madc_sel_type madc_decode(input logic [ADDR_W-1:0] a);
    madc_sel_type s;
    s = SEL_NONE;
    if (a == OFS_CMD)         s = SEL_CMD;
    else if (a == OFS_IER)    s = SEL_IER;
    else if (a == OFS_ISR)    s = SEL_ISR;
    else if (a == OFS_STATUS) s = SEL_STAT;
    else if (a[ADDR_W-1:RAM_LSB] == OFS_RAM[ADDR_W-1:RAM_LSB] && a[1:0] == 2'b00) s = SEL_RAM;
    return s;
  endfunction : madc_decode

  // logical channel to {sensor select, macro channel}
  function automatic logic [CH_W:0] madc_map_chan(input logic [CH_W-1:0] lch);
    if (lch == TEMP_LCH) return {1'b1, TEMP_MCH};
    return {1'b0, CH_W'(lch + PIN_OFS)};
  endfunction : madc_map_chan

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [NCONV-1:0]       eoc_meta, eoc_sync;     // eoc synchroniser
  logic [NCONV*DAT_W-1:0] dout_meta, dout_sync;   // data synchroniser
  madc_sel_type           sel;                    // decoded access target
  logic                   acc_first, acc_done;    // apb access phases
  logic                   run, mode;              // command register
  logic                   ier, isr;               // block interrupt regs
  logic [SLOT_W-1:0]      slot;                   // next slot to issue
  logic                   powered;                // sequencer view of power
  logic                   cmd_valid;              // command stream
  madc_op_type            cmd_op;
  logic [SLOT_W-1:0]      cmd_slot;
  logic                   cmd_ready, cmd_take;
  madc_state_type         state;                  // control core state
  logic [CNT_W-1:0]       cnt;                    // power-up and gap timer
  logic [1:0]             since_ack;              // cycles since last accept
  logic                   wait_next, cont_next;   // continuity tracking
  logic [NCONV-1:0]       sync_req;               // per-core sync requests
  logic                   sync_grant;             // synchronizer grant
  logic                   resp_valid;             // response stream, no ready
  logic [SLOT_W-1:0]      resp_slot;
  logic [NCONV*DAT_W-1:0] resp_data;
  logic [NCONV*CH_W-1:0]  resp_chan;
  logic [31:0]            merged;                 // word written to ram
  logic [31:0]            ram_q;

  // ----------------------------------------------------------------
  // converter input synchronisers
  // ----------------------------------------------------------------
  // macro signals come from its own clock; two stages before any use
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      eoc_meta  <= '0;
      eoc_sync  <= '0;
      dout_meta <= '0;
      dout_sync <= '0;
    end else begin
      eoc_meta  <= conv_eoc;
      eoc_sync  <= eoc_meta;
      dout_meta <= conv_dout;
      dout_sync <= dout_meta;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign sel       = madc_decode(paddr);
  assign acc_first = psel && penable && !pready;
  assign acc_done  = psel && penable && pready;

  // every access gets exactly one wait state so ram reads line up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (acc_first) begin
      pready  <= 1'b1;
      pslverr <= (sel == SEL_NONE) || (sel == SEL_RAM && pwrite);  // ram is read only
      unique case (sel)
        SEL_CMD:  prdata <= {30'h0, mode, run};
        SEL_IER:  prdata <= {31'h0, ier};
        SEL_ISR:  prdata <= {31'h0, isr};
        SEL_STAT: prdata <= {24'h0, slot, powered, state == ST_CONV};
        SEL_RAM:  prdata <= ram_q;
        SEL_NONE: prdata <= 32'h0;
      endcase
    end else begin
      pready  <= 1'b0;   // release after the completing edge
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: command register
  // ----------------------------------------------------------------
  // a software write lands after the hardware clear, so a fresh set is never lost
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run  <= CMD_RUN_RST;
      mode <= CMD_MODE_RST;
    end else begin
      if (cmd_take && cmd_op == OP_CONV && cmd_slot == LAST_SLOT && !mode) begin
        run <= 1'b0;
      end
      if (acc_done && pwrite && sel == SEL_CMD) begin
        run  <= pwdata[CMD_RUN_BIT];
        mode <= pwdata[CMD_MODE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer: command issue
  // ----------------------------------------------------------------
  // slots come from a build-time table; the command is re-raised the cycle after an accept
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_valid <= 1'b0;
      cmd_op    <= OP_PWRDN;
      cmd_slot  <= '0;
      slot      <= '0;
      powered   <= 1'b0;
    end else if (cmd_take) begin
      cmd_valid <= 1'b0;
      unique case (cmd_op)
        OP_PWRUP: powered <= 1'b1;
        OP_PWRDN: powered <= 1'b0;
        OP_CONV:  slot    <= (cmd_slot == LAST_SLOT) ? '0 : cmd_slot + 1'b1;
        default:  powered <= powered;                                         // illegal code
      endcase
    end else if (!cmd_valid) begin
      if (!powered && run) begin
        cmd_valid <= 1'b1;
        cmd_op    <= OP_PWRUP;
      end else if (powered && (run || slot != '0)) begin
        // a cleared run still finishes the pass in progress
        cmd_valid <= 1'b1;
        cmd_op    <= OP_CONV;
        cmd_slot  <= slot;
      end else if (powered) begin
        cmd_valid <= 1'b1;
        cmd_op    <= OP_PWRDN;
      end
    end
  end

  // ----------------------------------------------------------------
  // control core: command acceptance
  // ----------------------------------------------------------------
  // ready only while idle or powered and waiting, so at most one command is held
  assign cmd_ready = (state == ST_READY) || (state == ST_OFF);
  assign cmd_take  = cmd_valid && cmd_ready;

  // measure how soon the next command follows an accept
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      since_ack <= 2'h0;
      wait_next <= 1'b0;
      cont_next <= 1'b0;
    end else if (cmd_take) begin
      since_ack <= 2'h0;
      wait_next <= 1'b1;
    end else if (wait_next) begin
      if (cmd_valid) begin
        wait_next <= 1'b0;
        cont_next <= (since_ack < 2'(CONT_WIN_CYC));
      end else if (since_ack != 2'h3) begin
        since_ack <= since_ack + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control core: state machine
  // ----------------------------------------------------------------
  // start is a level held until the synchronised end of conversion, because a
  // single sys_clk pulse could be missed by the slower converter clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= ST_OFF;
      conv_pd    <= 1'b1;
      conv_start <= 1'b0;
      conv_cont  <= 1'b0;
      cnt        <= '0;
      resp_slot  <= '0;
    end else begin
      unique case (state)
        ST_OFF, ST_READY: begin
          if (cmd_take) begin
            unique case (cmd_op)
              OP_PWRUP: begin
                conv_pd <= 1'b0;
                cnt     <= CNT_W'(PWRUP_CYC);
                state   <= ST_PWRUP;
              end
              OP_PWRDN: begin
                conv_pd <= 1'b1;
                state   <= ST_OFF;
              end
              OP_CONV: begin
                conv_start <= 1'b1;
                conv_cont  <= cont_next;
                resp_slot  <= cmd_slot;
                state      <= ST_CONV;
              end
              default: state <= state;                           // illegal code ignored
            endcase
          end
        end
        ST_PWRUP: begin
          if (cnt <= CNT_W'(1)) state <= ST_READY;
          else cnt <= cnt - 1'b1;
        end
        ST_CONV: begin
          if (sync_grant) begin
            conv_start <= 1'b0;
            cnt        <= CNT_W'(RESP_GAP_CYC);
            state      <= ST_GAP;
          end
        end
        ST_GAP: begin
          // hold off the next command so responses stay a microsecond apart
          if (cnt > CNT_W'(1)) cnt <= cnt - 1'b1;
          else if (eoc_sync == '0) state <= ST_READY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // synchronizer and response
  // ----------------------------------------------------------------
  // grant only when every core has seen its end of conversion
  assign sync_grant = &sync_req;

  // one-cycle response pulse; nothing downstream may stall it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= (state == ST_CONV) && sync_grant;
    end
  end

  // ----------------------------------------------------------------
  // per-converter logic
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < NCONV; gi++) begin : g_conv
    logic [CH_W-1:0]  lch;    // logical channel of the issued slot
    logic [DAT_W-1:0] smp;    // captured sample
    logic [CH_W-1:0]  rch;    // channel of the captured sample
    assign lch = SLOT_CHAN[(gi*MAX_SLOTS + int'(cmd_slot))*CH_W +: CH_W];
    assign smp = resp_data[gi*DAT_W +: DAT_W];
    assign rch = resp_chan[gi*CH_W +: CH_W];

    // sync request raised on the converter event, dropped on grant
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        sync_req[gi] <= 1'b0;
      end else if (sync_grant) begin
        sync_req[gi] <= 1'b0;
      end else if (state == ST_CONV && eoc_sync[gi]) begin
        sync_req[gi] <= 1'b1;
      end
    end

    // channel selection on accept, sample capture on grant
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        conv_tsd[gi]                   <= 1'b0;
        conv_chsel[gi*CH_W +: CH_W]    <= '0;
        resp_chan[gi*CH_W +: CH_W]     <= '0;
        resp_data[gi*DAT_W +: DAT_W]   <= '0;
      end else begin
        if (cmd_take && cmd_op == OP_CONV) begin
          {conv_tsd[gi], conv_chsel[gi*CH_W +: CH_W]} <= madc_map_chan(lch);
          resp_chan[gi*CH_W +: CH_W] <= lch;
        end
        if (state == ST_CONV && sync_grant) begin
          resp_data[gi*DAT_W +: DAT_W] <= dout_sync[gi*DAT_W +: DAT_W];
        end
      end
    end

    // threshold checker with build-time limits and enables
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        thr_valid[gi]             <= 1'b0;
        thr_above[gi]             <= 1'b0;
        thr_below[gi]             <= 1'b0;
        thr_chan[gi*CH_W +: CH_W] <= '0;
      end else begin
        thr_valid[gi] <= resp_valid && ((MAX_EN[rch] && smp > MAX_LIMIT) ||
                                        (MIN_EN[rch] && smp < MIN_LIMIT));
        if (resp_valid) begin
          thr_above[gi]             <= MAX_EN[rch] && (smp > MAX_LIMIT);
          thr_below[gi]             <= MIN_EN[rch] && (smp < MIN_LIMIT);
          thr_chan[gi*CH_W +: CH_W] <= rch;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // response merger and sample store
  // ----------------------------------------------------------------
  // with two converters both lanes land in one word; with one the upper lane is zero
  always_comb begin
    merged = 32'h0;
    for (int i = 0; i < NCONV; i++) begin
      merged[i*LANE_W +: LANE_W] = LANE_W'(resp_data[i*DAT_W +: DAT_W]);
    end
  end

  madc_ram #(
    .WIDTH (32),
    .DEPTH (MAX_SLOTS),
    .AW    (SLOT_W)
  ) u_ram (
    .sys_clk (sys_clk),
    .wr_en   (resp_valid),
    .wr_addr (resp_slot),
    .wr_data (merged),
    .rd_addr (paddr[SLOT_W+1:2]),
    .rd_data (ram_q)
  );

  // ----------------------------------------------------------------
  // block complete flag and interrupt
  // ----------------------------------------------------------------
  // completion beats a clear in the same cycle so no pass goes unseen
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ier       <= IER_RST;
      isr       <= ISR_RST;
      block_irq <= 1'b0;
    end else begin
      if (acc_done && pwrite && sel == SEL_IER) ier <= pwdata[IER_BLK_BIT];
      if (resp_valid && resp_slot == LAST_SLOT) begin
        isr <= 1'b1;
      end else if (acc_done && pwrite && sel == SEL_ISR && pwdata[ISR_BLK_BIT]) begin
        isr <= 1'b0;
      end
      block_irq <= IRQ_EN && isr && ier;
    end
  end

endmodule : madc_top
